/* File: hdl/pbmr_regs.vh */
/*
 * register offsets, field positions, reset values and timing counts for the
 * clause-22 basic management register bank.
 * assumes inclusion by bare name from the design files of this block.
 */
`ifndef PBMR_REGS_VH
`define PBMR_REGS_VH

// register addresses (5-bit management register address)
`define PBMR_ADDR_CTRL 5'h00
`define PBMR_ADDR_STAT 5'h01
`define PBMR_ADDR_IDU 5'h02
`define PBMR_ADDR_IDL 5'h03
`define PBMR_ADDR_ADV 5'h04
`define PBMR_ADDR_LPA 5'h05
`define PBMR_ADDR_EXP 5'h06
`define PBMR_ADDR_NPT 5'h07

// control field positions
`define PBMR_CTRL_RESET 15
`define PBMR_CTRL_SPD0 13
`define PBMR_CTRL_ANEN 12
`define PBMR_CTRL_PWD 11
`define PBMR_CTRL_RSAN 9
`define PBMR_CTRL_DUPLEX 8
`define PBMR_CTRL_COLTEST 7
`define PBMR_CTRL_SPD1 6

// reset values, fixed read bits and write masks
`define PBMR_CTRL_RST 16'h3100
`define PBMR_STAT_FIXED 16'h7949
`define PBMR_ADV_RST 16'h1de1
`define PBMR_ADV_WMASK 16'hbde0
`define PBMR_ADV_SEL 16'h0001
`define PBMR_NPT_RST 16'h0001
`define PBMR_NPT_WMASK 16'ha7ff
`define PBMR_EXP_LOCAL_NP 16'h0004

// management frame fields
`define PBMR_PHYAD_RST 5'h00
`define PBMR_ST_OP_RD 4'h6
`define PBMR_ST_OP_WR 4'h5
`define PBMR_PREAMBLE_BITS 6'h20

`endif

/* File: hdl/pbmr_sync.v */
/*
 * two flip-flop synchroniser for a group of asynchronous levels.
 * assumes inputs come from pins or another clock domain and idle high.
 */
`timescale 1ns/10ps
module pbmr_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta;

// first stage only feeds the second
always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        // park at the idle-high level so no false edge follows reset
        meta <= {WIDTH{1'b1}};
        sync_o <= {WIDTH{1'b1}};
    end else begin
        meta <= async_i;
        sync_o <= meta;
    end
end

endmodule // pbmr_sync

/* File: hdl/pbmr_top.v */
/*
 * clause-22 basic management register bank of a 10/100 transceiver, with its
 * serial management slave (management clock sampled as an ordinary input).
 * assumes MDC and MDIO_I are asynchronous pins; negotiation and link status
 * arrive as levels/pulses from logic on CLK_I.
 */
`timescale 1ns/10ps
`include "pbmr_regs.vh"

// Overview of operation
// RULE1: with negotiation off, control bit 8 forces duplex; bit 7 enables collision test
// RULE2: after negotiation completes, duplex bit reads the resolved duplex
// RULE3: control bit 6 is upper speed bit, bit 13 the lower
// RULE4: speed 01 is 100 Mb/s, 00 is 10; lower bit follows resolved speed
// RULE5: status bit 15 reads 0, bits 14 to 11 read 1
// RULE6: status bit 8 reads 1, extended status exists
// RULE7: status bit 7 reads 0, transmit only with valid link
// RULE8: status bit 6 reads 1; frames without preamble are accepted
// RULE9: controller sends 32 preamble bits first, one idle bit between frames
// RULE10: status bit 5 shows negotiation complete
// RULE11: status bit 4 latches remote fault, cleared by read or reset
// RULE12: status bit 3 reads 1, negotiation capable
// RULE13: status bit 2 latches low on link loss; read twice for current state
// RULE14: status bit 1 reads jabber detected
// RULE15: status bit 0 permanently reads 1
// RULE16: identifier registers return id bits, model and revision, read-only
// RULE17: advertisement selector reads 00001, bit 9 reads 0
// RULE18: advertisement writes read back at once, apply on reset, restart, wake, link loss
// RULE19: advertisement defaults bits 12,11,10,8..5 set, 15 and 13 clear
// RULE20: partner register captures abilities; parallel detect sets bit 7 or 5
// RULE21: partner register takes latest received page when next pages used
// RULE22: expansion bits 4 and 1 clear on read; 3, 2, 0 report abilities
// RULE23: next-page transmit holds bit 15 more pages, bit 13 message page
// RULE24: writes to read-only or reserved bits ignored; reserved reads zero
module pbmr_top #(
    parameter [5:0] ID_TOP = 6'h2a,    // arbitrary value
    parameter [15:0] ID_MID = 16'h1234, // arbitrary value
    parameter [5:0] MODEL = 6'h05,     // arbitrary value
    parameter [3:0] REVISION = 4'h1,   // arbitrary value
    parameter [4:0] PHY_ADDR = `PBMR_PHYAD_RST
) (
    input wire CLK_I,
    input wire RSTN_I,
    input wire MDC_I,
    input wire MDIO_I,
    input wire NEG_DONE_I,
    input wire RES_FULL_I,
    input wire RES_100_I,
    input wire LINK_UP_I,
    input wire REMOTE_FAULT_I,
    input wire JABBER_I,
    input wire PAGE_RX_I,
    input wire [15:0] PAGE_DATA_I,
    input wire PAR_DET_I,
    input wire PAR_DET_100_I,
    input wire PAR_DET_FAULT_I,
    input wire PARTNER_NEG_CAPABLE_I,
    output reg MDIO_O,
    output reg MDIO_OE_O,
    output reg FULL_DUPLEX_O,
    output reg SPEED_100_O,
    output reg COLLISION_TEST_O,
    output reg NEG_ENABLE_O,
    output reg NEG_RESTART_O,
    output reg POWER_DOWN_O,
    output reg [15:0] ADVERT_ACTIVE_O,
    output reg [15:0] NEXT_PAGE_O
);

////////////////////////////////////////////////////////////////////////////////
wire [1:0] pin_sync;
reg mdc_prev;
wire mdc_rise;
wire mdc_fall;
wire mdio_in;

// management pins pass two flops before anything looks at them
pbmr_sync #(.WIDTH(2)) u_sync (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .async_i({MDC_I, MDIO_I}),
    .sync_o(pin_sync)
);

assign mdio_in = pin_sync[0];
assign mdc_rise = pin_sync[1] & ~mdc_prev;
assign mdc_fall = ~pin_sync[1] & mdc_prev;

////////////////////////////////////////////////////////////////////////////////
// serial frame states
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_HEAD = 3'h1;
localparam [2:0] S_TA = 3'h2;
localparam [2:0] S_RDATA = 3'h3;
localparam [2:0] S_WDATA = 3'h4;

reg [2:0] state;
reg [5:0] ones_cnt;
reg [5:0] bit_cnt;
reg [13:0] head;
reg [15:0] shift;
reg is_read;
reg addr_hit;
reg [4:0] reg_addr;
reg wr_pulse;
reg rd_pulse;
reg [15:0] wr_data;
wire [15:0] rd_data;

// frame decode; a start of frame is accepted with or without preamble
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        mdc_prev <= 1'b1;
        state <= S_IDLE;
        ones_cnt <= 6'h00;
        bit_cnt <= 6'h00;
        head <= 14'h0000;
        shift <= 16'h0000;
        is_read <= 1'b0;
        addr_hit <= 1'b0;
        reg_addr <= 5'h00;
        wr_pulse <= 1'b0;
        rd_pulse <= 1'b0;
        wr_data <= 16'h0000;
        MDIO_O <= 1'b0;
        MDIO_OE_O <= 1'b0;
    end else begin
        mdc_prev <= pin_sync[1];
        wr_pulse <= 1'b0;
        rd_pulse <= 1'b0;
        if (mdc_rise) begin
            case (state)
                S_IDLE: begin
                    // a zero after ones is the first start bit
                    if (!mdio_in && ones_cnt != 6'h00) begin // RULE8
                        state <= S_HEAD;
                        bit_cnt <= 6'h01;
                        head <= 14'h0000;
                    end
                end
                S_HEAD: begin
                    head <= {head[12:0], mdio_in};
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h0d) begin
                        reg_addr <= {head[3:0], mdio_in};
                        addr_hit <= (head[8:4] == PHY_ADDR);
                        is_read <= ({1'b0, head[11:9]} == `PBMR_ST_OP_RD);
                        if ({1'b0, head[11:9]} == `PBMR_ST_OP_RD ||
                            {1'b0, head[11:9]} == `PBMR_ST_OP_WR) begin
                            state <= S_TA;
                        end else begin
                            state <= S_IDLE;
                        end
                        bit_cnt <= 6'h00;
                    end
                end
                S_TA: begin
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h01) begin
                        bit_cnt <= 6'h00;
                        state <= is_read ? S_RDATA : S_WDATA;
                    end
                end
                S_WDATA: begin
                    shift <= {shift[14:0], mdio_in};
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h0f) begin
                        wr_data <= {shift[14:0], mdio_in};
                        wr_pulse <= addr_hit;
                        state <= S_IDLE;
                    end
                end
                S_RDATA: begin
                    bit_cnt <= bit_cnt + 6'h01;
                    if (bit_cnt == 6'h0f) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
        // read data driven after falling edges; capture at second TA bit
        if (mdc_fall) begin
            if (state == S_TA && is_read && addr_hit && bit_cnt == 6'h01) begin
                MDIO_OE_O <= 1'b1;
                MDIO_O <= 1'b0;
                shift <= rd_data;
                rd_pulse <= 1'b1;
            end else if (state == S_RDATA && addr_hit) begin
                MDIO_O <= shift[15];
                shift <= {shift[14:0], 1'b0};
            end else begin
                MDIO_OE_O <= 1'b0;
                MDIO_O <= 1'b0;
            end
        end
        // run of ones before a start: preamble or at least the idle bit
        if (mdc_rise) begin
            ones_cnt <= !mdio_in ? 6'h00 : (ones_cnt == `PBMR_PREAMBLE_BITS) ?
                ones_cnt : ones_cnt + 6'h01; // RULE9
        end
    end
end

wire wr_ctrl = wr_pulse && reg_addr == `PBMR_ADDR_CTRL;
wire wr_adv = wr_pulse && reg_addr == `PBMR_ADDR_ADV;
wire wr_npt = wr_pulse && reg_addr == `PBMR_ADDR_NPT;
wire rd_stat = rd_pulse && reg_addr == `PBMR_ADDR_STAT;
wire rd_exp = rd_pulse && reg_addr == `PBMR_ADDR_EXP;

////////////////////////////////////////////////////////////////////////////////
reg [15:0] ctrl;
reg [15:0] adv;
reg [15:0] npt;
reg [15:0] lpa;
reg fault_latch;
reg link_latch;
reg pdf_latch;
reg page_latch;
reg link_prev;
reg sw_reset;

// control register; self-clearing reset and restart bits
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        ctrl <= `PBMR_CTRL_RST;
        sw_reset <= 1'b0;
        NEG_RESTART_O <= 1'b0;
    end else begin
        sw_reset <= wr_ctrl && wr_data[`PBMR_CTRL_RESET];
        NEG_RESTART_O <= wr_ctrl && wr_data[`PBMR_CTRL_RSAN];
        if (sw_reset) begin
            ctrl <= `PBMR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= {1'b0, wr_data[14:10], 1'b0, wr_data[8:6], 6'h00}; // RULE24
        end else if (NEG_DONE_I && ctrl[`PBMR_CTRL_ANEN]) begin
            ctrl[`PBMR_CTRL_DUPLEX] <= RES_FULL_I; // RULE2
            ctrl[`PBMR_CTRL_SPD0] <= RES_100_I; // RULE4
            ctrl[`PBMR_CTRL_SPD1] <= 1'b0;
        end
    end
end

// advertisement and next page; written value visible at once
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        adv <= `PBMR_ADV_RST; // RULE19
        npt <= `PBMR_NPT_RST;
        ADVERT_ACTIVE_O <= `PBMR_ADV_RST;
        link_prev <= 1'b0;
    end else begin
        link_prev <= LINK_UP_I;
        if (sw_reset) begin
            adv <= `PBMR_ADV_RST;
            npt <= `PBMR_NPT_RST;
        end else begin
            if (wr_adv) begin
                adv <= (wr_data & `PBMR_ADV_WMASK) | `PBMR_ADV_SEL; // RULE17 RULE18
            end
            if (wr_npt) begin
                npt <= wr_data & `PBMR_NPT_WMASK; // RULE23
            end
        end
        // new advertisement applies on reset, restart, wake or link loss
        // adv is still reloading during a software reset, so apply defaults
        if (sw_reset) begin
            ADVERT_ACTIVE_O <= `PBMR_ADV_RST; // RULE18
        end else if ((wr_ctrl && wr_data[`PBMR_CTRL_RSAN]) ||
            (wr_ctrl && ctrl[`PBMR_CTRL_PWD] && !wr_data[`PBMR_CTRL_PWD]) ||
            (link_prev && !LINK_UP_I)) begin
            ADVERT_ACTIVE_O <= adv; // RULE18
        end
    end
end

// partner ability and latched status; a set beats a clear on read
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        lpa <= 16'h0000;
        fault_latch <= 1'b0;
        link_latch <= 1'b0;
        pdf_latch <= 1'b0;
        page_latch <= 1'b0;
    end else begin
        if (sw_reset) begin
            lpa <= 16'h0000;
        end else if (PAGE_RX_I) begin
            lpa <= {PAGE_DATA_I[15:13], 1'b0, PAGE_DATA_I[11:0]}; // RULE20 RULE21
        end else if (PAR_DET_I) begin
            if (PAR_DET_100_I) begin
                lpa[7] <= 1'b1; // RULE20
            end else begin
                lpa[5] <= 1'b1; // RULE20
            end
        end
        fault_latch <= REMOTE_FAULT_I | (fault_latch & ~rd_stat & ~sw_reset); // RULE11
        // low latch: drops on loss, recovers only when read
        link_latch <= LINK_UP_I & (link_latch | rd_stat); // RULE13
        pdf_latch <= PAR_DET_FAULT_I | (pdf_latch & ~rd_exp); // RULE22
        page_latch <= PAGE_RX_I | (page_latch & ~rd_exp); // RULE22
    end
end

////////////////////////////////////////////////////////////////////////////////
wire [15:0] stat_word = `PBMR_STAT_FIXED // RULE5 RULE6 RULE7 RULE8 RULE12 RULE15
    | {10'h000, NEG_DONE_I, fault_latch, 1'b0, link_latch, JABBER_I, 1'b0}; // RULE10 RULE14
wire [15:0] exp_word = `PBMR_EXP_LOCAL_NP
    | {11'h000, pdf_latch, lpa[15], 1'b0, page_latch, PARTNER_NEG_CAPABLE_I}; // RULE22
reg [15:0] rd_mux;

// read multiplexer; unmapped addresses read zero
always @* begin
    case (reg_addr)
        `PBMR_ADDR_CTRL: rd_mux = ctrl;
        `PBMR_ADDR_STAT: rd_mux = stat_word;
        `PBMR_ADDR_IDU: rd_mux = ID_MID; // RULE16
        `PBMR_ADDR_IDL: rd_mux = {ID_TOP, MODEL, REVISION}; // RULE16
        `PBMR_ADDR_ADV: rd_mux = adv;
        `PBMR_ADDR_LPA: rd_mux = lpa;
        `PBMR_ADDR_EXP: rd_mux = exp_word;
        `PBMR_ADDR_NPT: rd_mux = npt;
        default: rd_mux = 16'h0000;
    endcase
end
assign rd_data = rd_mux;

// control outputs to the data path
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        FULL_DUPLEX_O <= 1'b1;
        SPEED_100_O <= 1'b1;
        COLLISION_TEST_O <= 1'b0;
        NEG_ENABLE_O <= 1'b1;
        POWER_DOWN_O <= 1'b0;
        NEXT_PAGE_O <= `PBMR_NPT_RST;
    end else begin
        FULL_DUPLEX_O <= ctrl[`PBMR_CTRL_DUPLEX]; // RULE1
        // reserved codes with upper bit set fall back to 10 Mb/s
        SPEED_100_O <= ~ctrl[`PBMR_CTRL_SPD1] & ctrl[`PBMR_CTRL_SPD0]; // RULE3 RULE4
        COLLISION_TEST_O <= ctrl[`PBMR_CTRL_COLTEST]; // RULE1
        NEG_ENABLE_O <= ctrl[`PBMR_CTRL_ANEN];
        POWER_DOWN_O <= ctrl[`PBMR_CTRL_PWD];
        NEXT_PAGE_O <= npt;
    end
end

endmodule // pbmr_top

/* File: testbench/pbmr_top_sva.sv */
/* checker for the outputs of the basic management register bank.
   assumes it is bound onto pbmr_top, one clock domain on CLK_I. */
`timescale 1ns/10ps
module pbmr_top_sva (
    input wire CLK_I,
    input wire RSTN_I,
    input wire MDC_I,
    input wire NEG_DONE_I,
    input wire RES_FULL_I,
    input wire RES_100_I,
    input wire LINK_UP_I,
    input wire MDIO_OE_O,
    input wire FULL_DUPLEX_O,
    input wire SPEED_100_O,
    input wire COLLISION_TEST_O,
    input wire NEG_ENABLE_O,
    input wire NEG_RESTART_O,
    input wire [15:0] ADVERT_ACTIVE_O,
    input wire [15:0] NEXT_PAGE_O
);
    default clocking dc @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    ////////////////////////////////////////////////////////////////////////
    // cycles since the last management clock or link change, saturating
    reg mdc_q;
    reg link_q;
    reg [4:0] mdc_cnt;
    reg [4:0] link_cnt;
    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mdc_q <= 1'b1;
            link_q <= 1'b0;
            mdc_cnt <= 5'h00;
            link_cnt <= 5'h00;
        end else begin
            mdc_q <= MDC_I;
            link_q <= LINK_UP_I;
            mdc_cnt <= (MDC_I != mdc_q) ? 5'h00 : mdc_cnt + {4'h0, mdc_cnt != 5'h1f};
            link_cnt <= (LINK_UP_I != link_q) ? 5'h00 : link_cnt + {4'h0, link_cnt != 5'h1f};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // 12 cycles of quiet covers synchroniser, write and output register
    property p_forced_duplex;
        !NEG_ENABLE_O && mdc_cnt >= 5'h0c |-> $stable(FULL_DUPLEX_O) && $stable(COLLISION_TEST_O);
    endproperty
    a_forced_duplex: assert property (p_forced_duplex)
        else $error("forced duplex or collision test moved without a write");
    property p_resolved_duplex;
        (NEG_DONE_I && NEG_ENABLE_O && $stable(RES_FULL_I))[*5] |-> FULL_DUPLEX_O == RES_FULL_I;
    endproperty
    a_resolved_duplex: assert property (p_resolved_duplex)
        else $error("duplex output does not follow resolved duplex");
    property p_resolved_speed;
        (NEG_DONE_I && NEG_ENABLE_O && !RES_100_I)[*5] |-> !SPEED_100_O;
    endproperty
    a_resolved_speed: assert property (p_resolved_speed)
        else $error("speed output high while resolved speed is 10");
    property p_adv_fixed;
        ADVERT_ACTIVE_O[4:0] == 5'h01 && !ADVERT_ACTIVE_O[9] && !ADVERT_ACTIVE_O[14];
    endproperty
    a_adv_fixed: assert property (p_adv_fixed)
        else $error("fixed advertisement bits wrong");
    property p_adv_apply;
        $changed(ADVERT_ACTIVE_O) |-> mdc_cnt < 5'h0c || link_cnt < 5'h0c;
    endproperty
    a_adv_apply: assert property (p_adv_apply)
        else $error("active advertisement changed with no trigger");
    property p_restart_pulse;
        NEG_RESTART_O |-> mdc_cnt < 5'h0c ##1 !NEG_RESTART_O;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("restart pulse too long or without a write");
    property p_npt_hold;
        !NEXT_PAGE_O[14] && (!$changed(NEXT_PAGE_O) || mdc_cnt < 5'h0c);
    endproperty
    a_npt_hold: assert property (p_npt_hold)
        else $error("next page output changed without a write");
    property p_mdio_quiet;
        MDIO_OE_O |-> mdc_cnt < 5'h0c;
    endproperty
    a_mdio_quiet: assert property (p_mdio_quiet)
        else $error("data pin driven with management clock idle");
    c_restart: cover property (NEG_RESTART_O);
    c_read: cover property ($rose(MDIO_OE_O));
    c_link_loss: cover property ($fell(LINK_UP_I));
endmodule // pbmr_top_sva
bind pbmr_top pbmr_top_sva u_sva (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .MDC_I(MDC_I),
    .NEG_DONE_I(NEG_DONE_I), .RES_FULL_I(RES_FULL_I), .RES_100_I(RES_100_I),
    .LINK_UP_I(LINK_UP_I), .MDIO_OE_O(MDIO_OE_O), .FULL_DUPLEX_O(FULL_DUPLEX_O),
    .SPEED_100_O(SPEED_100_O), .COLLISION_TEST_O(COLLISION_TEST_O),
    .NEG_ENABLE_O(NEG_ENABLE_O), .NEG_RESTART_O(NEG_RESTART_O),
    .ADVERT_ACTIVE_O(ADVERT_ACTIVE_O), .NEXT_PAGE_O(NEXT_PAGE_O));

/* File: testbench/pbmr_smi_ctrl.sv */
/* station management controller model: clause-22 frames on clock and data.
   assumes a pull-up on the data line; clock stands high between frames. */
`timescale 1ns/10ps
module pbmr_smi_ctrl (
    input wire clk_i,
    input wire mdio_i,
    output reg mdc_o,
    output reg mdio_o,
    output reg mdio_oe_o
);
    reg first = 1'b1;
    initial begin
        mdc_o = 1'b1;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one bit: 8 system clocks, sampled mid-high to clear the answer latency
    task bit_cycle(input logic drv, input logic b, output logic s);
        begin
            mdio_oe_o <= drv;
            mdio_o <= b;
            mdc_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            mdc_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            s = mdio_i;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // whole frame; released during turnaround and data of a read
    task xfer(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
              input logic [15:0] wd, output logic [15:0] q);
        logic [31:0] hdr;
        logic s;
        integer i;
        begin
            if (first) for (i = 0; i < 32; i = i + 1) bit_cycle(1'b1, 1'b1, s);
            first = 1'b0;
            hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
            for (i = 31; i >= 0; i = i - 1) begin
                bit_cycle(!(rd && i < 18), hdr[i], s);
                if (i < 16) q[i] = s;
            end
            bit_cycle(1'b0, 1'b1, s);
        end
    endtask
endmodule // pbmr_smi_ctrl

/* File: testbench/phy_basic_mgmt_registers_test.sv */
/* self-checking bench for the basic management register bank.
   assumes pbmr_top, the controller model and the bound checker. */
`timescale 1ns/10ps
module phy_basic_mgmt_registers_test;
    localparam [5:0] id_top = 6'h15; // arbitrary value
    localparam [15:0] id_mid = 16'hbeef; // arbitrary value
    localparam [5:0] id_model = 6'h33; // arbitrary value
    localparam [3:0] id_rev = 4'h9; // arbitrary value
    typedef struct packed {logic wr; logic [4:0] a; logic [15:0] d, m, e; logic [3:0] o;} pbmr_row_t;
    reg CLK_I = 1'b0;
    reg RSTN_I = 1'b0;
    reg NEG_DONE_I = 1'b0, RES_FULL_I = 1'b0, RES_100_I = 1'b0, LINK_UP_I = 1'b0;
    reg REMOTE_FAULT_I = 1'b0, JABBER_I = 1'b0, PAGE_RX_I = 1'b0, PAR_DET_I = 1'b0;
    reg PAR_DET_100_I = 1'b0, PAR_DET_FAULT_I = 1'b0, PARTNER_NEG_CAPABLE_I = 1'b0;
    reg [15:0] PAGE_DATA_I = 16'h0000;
    wire MDC_I, MDIO_O, MDIO_OE_O, m_do, m_oe, FULL_DUPLEX_O, SPEED_100_O, COLLISION_TEST_O;
    wire NEG_ENABLE_O, NEG_RESTART_O, POWER_DOWN_O;
    wire [15:0] ADVERT_ACTIVE_O, NEXT_PAGE_O;
    // pull-up wins when neither end drives
    wire mdio_w = MDIO_OE_O ? MDIO_O : (m_oe ? m_do : 1'b1);
    wire [15:0] outs = {11'h000, POWER_DOWN_O, FULL_DUPLEX_O, SPEED_100_O, COLLISION_TEST_O,
        NEG_ENABLE_O};
    integer miscompares = 0, checks_done = 0, i;
    logic [15:0] q;
    pbmr_row_t rows [0:14];
    pbmr_row_t r;
    always #4 CLK_I = ~CLK_I;
    pbmr_smi_ctrl u_mgmt (.clk_i(CLK_I), .mdio_i(mdio_w), .mdc_o(MDC_I), .mdio_o(m_do),
        .mdio_oe_o(m_oe));
    pbmr_top #(.ID_TOP(id_top), .ID_MID(id_mid), .MODEL(id_model), .REVISION(id_rev)) DUT (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .MDC_I(MDC_I), .MDIO_I(mdio_w),
        .NEG_DONE_I(NEG_DONE_I), .RES_FULL_I(RES_FULL_I), .RES_100_I(RES_100_I),
        .LINK_UP_I(LINK_UP_I), .REMOTE_FAULT_I(REMOTE_FAULT_I), .JABBER_I(JABBER_I),
        .PAGE_RX_I(PAGE_RX_I), .PAGE_DATA_I(PAGE_DATA_I), .PAR_DET_I(PAR_DET_I),
        .PAR_DET_100_I(PAR_DET_100_I), .PAR_DET_FAULT_I(PAR_DET_FAULT_I),
        .PARTNER_NEG_CAPABLE_I(PARTNER_NEG_CAPABLE_I), .MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O),
        .FULL_DUPLEX_O(FULL_DUPLEX_O), .SPEED_100_O(SPEED_100_O),
        .COLLISION_TEST_O(COLLISION_TEST_O), .NEG_ENABLE_O(NEG_ENABLE_O),
        .NEG_RESTART_O(NEG_RESTART_O), .POWER_DOWN_O(POWER_DOWN_O),
        .ADVERT_ACTIVE_O(ADVERT_ACTIVE_O), .NEXT_PAGE_O(NEXT_PAGE_O));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge CLK_I);
    endtask
    task rdm(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        begin
            u_mgmt.xfer(1'b1, 5'h00, a, 16'h0000, q);
            chk(q & m, e);
        end
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        u_mgmt.xfer(1'b0, 5'h00, a, d, q);
    endtask
    task test_done;
        begin
            if (miscompares == 0 && checks_done > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    // watchdog cuts a hang short
    initial begin
        tick(60000);
        miscompares = miscompares + 1;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        // wr, addr, data, mask, expected, {duplex, speed, colltest, neg enable}
        rows[0] = {1'b0, 5'h00, 16'h0000, 16'hffff, 16'h3100, 4'hd};
        rows[1] = {1'b0, 5'h01, 16'h0000, 16'hffff, 16'h7949, 4'hd};
        rows[2] = {1'b0, 5'h02, 16'h0000, 16'hffff, id_mid, 4'hd};
        rows[3] = {1'b0, 5'h03, 16'h0000, 16'hffff, id_top, id_model, id_rev, 4'hd};
        rows[4] = {1'b0, 5'h04, 16'h0000, 16'hffff, 16'h1de1, 4'hd};
        rows[5] = {1'b0, 5'h05, 16'h0000, 16'hffff, 16'h0000, 4'hd};
        rows[6] = {1'b0, 5'h06, 16'h0000, 16'hffff, 16'h0004, 4'hd};
        rows[7] = {1'b0, 5'h07, 16'h0000, 16'he800, 16'h0000, 4'hd};
        rows[8] = {1'b1, 5'h01, 16'hffff, 16'hffff, 16'h7949, 4'hd};
        rows[9] = {1'b1, 5'h02, 16'h0000, 16'hffff, id_mid, 4'hd};
        rows[10] = {1'b1, 5'h04, 16'hffff, 16'hffff, 16'hbde1, 4'hd};
        rows[11] = {1'b1, 5'h04, 16'h0000, 16'hffff, 16'h0001, 4'hd};
        rows[12] = {1'b1, 5'h07, 16'hffff, 16'he800, 16'ha000, 4'hd};
        rows[13] = {1'b1, 5'h00, 16'h00c0, 16'h31c0, 16'h00c0, 4'h2};
        rows[14] = {1'b1, 5'h00, 16'h2100, 16'h31c0, 16'h2100, 4'hc};
        tick(20);
        RSTN_I <= 1'b1;
        tick(4);
        chk(ADVERT_ACTIVE_O, 16'h1de1);
        chk(NEXT_PAGE_O, 16'h0001);
        for (i = 0; i < 15; i = i + 1) begin
            r = rows[i];
            if (r.wr) wr(r.a, r.d);
            rdm(r.a, r.m, r.e);
            chk(outs, {12'h000, r.o});
        end
        // advertisement waits for restart, then for link loss
        chk(ADVERT_ACTIVE_O, 16'h1de1);
        chk(NEXT_PAGE_O & 16'he800, 16'ha000);
        wr(5'h00, 16'h1200);
        chk(ADVERT_ACTIVE_O, 16'h0001);
        chk(outs, 16'h0001);
        u_mgmt.xfer(1'b1, 5'h03, 5'h01, 16'h0000, q);
        chk(q, 16'hffff);
        NEG_DONE_I <= 1'b1;
        tick(8);
        rdm(5'h00, 16'h2100, 16'h0000);
        rdm(5'h01, 16'h0020, 16'h0020);
        RES_FULL_I <= 1'b1;
        RES_100_I <= 1'b1;
        tick(8);
        rdm(5'h00, 16'h2100, 16'h2100);
        NEG_DONE_I <= 1'b0;
        LINK_UP_I <= 1'b1;
        tick(8);
        rdm(5'h01, 16'h0024, 16'h0000);
        rdm(5'h01, 16'h0004, 16'h0004);
        wr(5'h04, 16'h01e1);
        LINK_UP_I <= 1'b0;
        tick(8);
        chk(ADVERT_ACTIVE_O, 16'h01e1);
        LINK_UP_I <= 1'b1;
        tick(8);
        rdm(5'h01, 16'h0004, 16'h0000);
        rdm(5'h01, 16'h0004, 16'h0004);
        REMOTE_FAULT_I <= 1'b1;
        JABBER_I <= 1'b1;
        tick(1);
        REMOTE_FAULT_I <= 1'b0;
        tick(8);
        rdm(5'h01, 16'h0012, 16'h0012);
        JABBER_I <= 1'b0;
        tick(8);
        rdm(5'h01, 16'h0012, 16'h0000);
        // partner page, parallel detect fault, clear on read
        PAGE_DATA_I <= 16'hffff;
        PAGE_RX_I <= 1'b1;
        PAR_DET_FAULT_I <= 1'b1;
        PARTNER_NEG_CAPABLE_I <= 1'b1;
        tick(1);
        PAGE_RX_I <= 1'b0;
        PAR_DET_FAULT_I <= 1'b0;
        tick(8);
        rdm(5'h05, 16'hffff, 16'hefff);
        rdm(5'h06, 16'h0017, 16'h0017);
        rdm(5'h06, 16'h0017, 16'h0005);
        PAGE_DATA_I <= 16'h0000;
        PAGE_RX_I <= 1'b1;
        tick(1);
        PAGE_RX_I <= 1'b0;
        tick(8);
        rdm(5'h05, 16'hffff, 16'h0000);
        for (i = 1; i >= 0; i = i - 1) begin
            PAR_DET_I <= 1'b1;
            PAR_DET_100_I <= i[0];
            tick(1);
            PAR_DET_I <= 1'b0;
            tick(8);
            rdm(5'h05, i[0] ? 16'h00a0 : 16'h0020, i[0] ? 16'h0080 : 16'h0020);
        end
        // power down, change advertisement, then waking applies it
        wr(5'h00, 16'h0800);
        chk(outs, 16'h0010);
        wr(5'h04, 16'h0de1);
        chk(ADVERT_ACTIVE_O, 16'h01e1);
        wr(5'h00, 16'h0000);
        chk(ADVERT_ACTIVE_O, 16'h0de1);
        wr(5'h00, 16'h8000);
        rdm(5'h04, 16'hffff, 16'h1de1);
        rdm(5'h00, 16'hffff, 16'h3100);
        chk(ADVERT_ACTIVE_O, 16'h1de1);
        chk(NEXT_PAGE_O, 16'h0001);
        // mid-run hardware reset clears the fault latch; preamble again after it
        REMOTE_FAULT_I <= 1'b1;
        tick(1);
        REMOTE_FAULT_I <= 1'b0;
        RSTN_I <= 1'b0;
        tick(2);
        RSTN_I <= 1'b1;
        u_mgmt.first = 1'b1;
        tick(4);
        chk(outs, 16'h000d);
        rdm(5'h01, 16'h0014, 16'h0000);
        test_done;
    end
endmodule // phy_basic_mgmt_registers_test
